// ===== hdl/sbcmr_pkg.sv
// Package with constants and types of the mode, interrupt, reset and wake-up controller
package sbcmr_pkg;
	typedef enum logic [2:0] {ST_RESET, ST_NREQ, ST_NORMAL, ST_STOP, ST_SLEEP} sbcmr_mode_type;
	// Mode select bit values written by the host
	localparam logic [1:0] MODE_SEL_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SEL_STOP = 2'h1;
	localparam logic [1:0] MODE_SEL_SLEEP = 2'h2;
	// Interrupt source bit positions
	localparam int SRC_WAKE = 0;
	localparam int SRC_LOW_V = 1;
	localparam int SRC_HIGH_V = 2;
	localparam int SRC_PREWARN = 3;
	localparam int SRC_LIN = 4;
	localparam int SRC_HS_OT = 5;
	localparam int SRC_LS_OT = 6;
	localparam int SRC_WIDTH = 7;
	// Reset values
	localparam logic [6:0] MASK_RESET = 7'h7f;
	localparam logic [3:0] WAKE_EN_RESET = 4'h0;
	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int RESET_EXT_US = 1000;
	localparam int NREQ_TIMEOUT_US = 150000;
	localparam int RESET_EXT_CYC = (CLK_HZ / 1000000) * RESET_EXT_US;
	localparam int NREQ_TIMEOUT_CYC = (CLK_HZ / 1000000) * NREQ_TIMEOUT_US;
	localparam int RST_FILTER_CYC = 4;
endpackage

// ===== hdl/sbcmr_ctrl.sv
// Operating-mode, interrupt, reset and wake-up controller
`timescale 1ns/1ps
// Overview of operation
// - Only the wake interrupt asserted while any wake-up source is still unread.
// - Stop mode interrupts only report wake-ups; Sleep mode raises none.
// - Interrupt line held low until host reads sources, then driven high.
// - Interrupts only in Normal, Normal Request, Stop, never with reset low.
// - Normal modes flag supply undervoltage and overvoltage interrupts.
// - Temperature prewarning raises an interrupt before regulator shutdown.
// - LIN thermal, stuck TXD, RXD short disable driver until cleared and read.
// - LIN over-current sets status flag and interrupt, driver stays enabled.
// - Separate high and low side thermal interrupts; sources maskable except wake-up.
// - Reset held while condition lasts, then at least 1.0 ms more.
// - Regulator output below reset threshold issues a reset.
// - Regulator over-temperature disables regulator and sets its flag.
// - Watchdog not serviced correctly in its open window resets the host.
// - Wake-up from Sleep runs a full power-up and reset sequence.
// - Filtered external reset low holds Reset-mode safe state, Stop included.
// - Released external reset adds no extension delay.
// - Low-power modes left on a wake-up or reset; only wake inputs need an enable, LIN, timer, CS do not.
// - Stop wake reported by interrupt; Sleep wake resets host; source readable.
// - Chip-select and external-reset wake-ups have no status bit.
// - Each wake input gated by its enable; input states reported.
// - Wake input routed to analog mux at low-power entry loses wake-up.
// - Normal Request uses fixed 150 ms timeout and LIN receive only.
// - Only high side switches cyclic-sense in Stop and Sleep; rest inactive.
// - Host selects operating mode by writing the two mode bits.
// - No Normal command within 150 ms Normal Request window returns to Reset.
module sbcmr_ctrl #(
	parameter int WAKE_INPUTS = 4,
	parameter int RESET_EXT_CYCLES = sbcmr_pkg::RESET_EXT_CYC,
	parameter int NREQ_CYCLES = sbcmr_pkg::NREQ_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Host mode command and register accesses
	input wire logic mode_write,
	input wire logic [1:0] mode_select_bits,
	input wire logic source_read,
	input wire logic [6:0] interrupt_mask_reg,
	input wire logic [WAKE_INPUTS-1:0] wake_input_enable,
	input wire logic [WAKE_INPUTS-1:0] wake_mux_select,
	input wire logic wd_disabled,
	input wire logic wd_fail,
	// Analog monitors
	input wire logic supply_undervoltage,
	input wire logic supply_overvoltage,
	input wire logic temp_prewarn,
	input wire logic vdd_below_reset,
	input wire logic vdd_overtemp,
	// Fault inputs from the drivers and wake sources
	input wire logic lin_overtemp,
	input wire logic txd_stuck,
	input wire logic rxd_short,
	input wire logic lin_overcurrent,
	input wire logic hs_overtemp,
	input wire logic ls_overtemp,
	input wire logic [WAKE_INPUTS-1:0] wake_input,
	input wire logic lin_wake,
	input wire logic timer_wake,
	input wire logic cs_rise,
	// Reset pin, three signals
	input wire logic rst_pin_in,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	// Interrupt pin, active low
	output logic irq_b,
	// Status to the host
	output logic [6:0] interrupt_source_reg,
	output logic [WAKE_INPUTS-1:0] wake_status_reg,
	output logic [WAKE_INPUTS-1:0] wake_source_reg,
	output logic lin_overcurrent_flag,
	output logic regulator_overtemp_flag,
	output logic [2:0] mode_state,
	// Function enables
	output logic vdd_enable,
	output logic vdd_low_power,
	output logic lin_tx_enable,
	output logic lin_rx_enable,
	output logic hs_cyclic_allowed,
	output logic peripherals_enable
);
	sbcmr_pkg::sbcmr_mode_type mode_r;
	logic [31:0] cnt_r;
	logic [2:0] filt_r;
	logic ext_rst;
	logic int_reset;
	logic [WAKE_INPUTS-1:0] wake_prev_r;
	logic [WAKE_INPUTS-1:0] wake_arm_r;
	logic [WAKE_INPUTS-1:0] wake_hit;
	logic wake_any;
	logic lin_fault_r;
	logic [6:0] events;
	logic irq_ok;
	logic irq_pending;

	assign ext_rst = (filt_r == 3'(sbcmr_pkg::RST_FILTER_CYC - 1)) && !rst_pin_in;
	// Internal reset causes; pin low from ourselves does not count as external
	assign int_reset = vdd_below_reset || vdd_overtemp
		|| (mode_r == sbcmr_pkg::ST_NORMAL && wd_fail && !wd_disabled);

	// Wake input edges gated by enable and by mux selection at entry
	genvar gi;
	generate
		for (gi = 0; gi < WAKE_INPUTS; gi++)
		begin : g_wake
			assign wake_hit[gi] = wake_arm_r[gi] && (wake_input[gi] != wake_prev_r[gi]);
		end
	endgenerate
	assign wake_any = (|wake_hit) || lin_wake || timer_wake;

	// Reset pin glitch filter
	always_ff @(posedge clk)
	begin
		if (!rst_b || rst_pin_oe || rst_pin_in)
			filt_r <= 3'h0;
		else if (filt_r != 3'(sbcmr_pkg::RST_FILTER_CYC - 1))
			filt_r <= filt_r + 3'h1;
	end

	// Mode state machine and its counter
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			mode_r <= sbcmr_pkg::ST_RESET;
			cnt_r <= 32'h0;
		end
		else if (int_reset || (ext_rst && mode_r != sbcmr_pkg::ST_SLEEP))
		begin
			mode_r <= sbcmr_pkg::ST_RESET;
			cnt_r <= ext_rst ? 32'(RESET_EXT_CYCLES) : 32'h0;
		end
		else
		begin
			case (mode_r)
				sbcmr_pkg::ST_RESET:
				begin
					if (cnt_r >= 32'(RESET_EXT_CYCLES - 1))
					begin
						mode_r <= wd_disabled ? sbcmr_pkg::ST_NORMAL : sbcmr_pkg::ST_NREQ;
						cnt_r <= 32'h0;
					end
					else
						cnt_r <= cnt_r + 32'h1;
				end
				sbcmr_pkg::ST_NREQ:
				begin
					if (mode_write && mode_select_bits == sbcmr_pkg::MODE_SEL_NORMAL)
						mode_r <= sbcmr_pkg::ST_NORMAL;
					else if (cnt_r >= 32'(NREQ_CYCLES - 1))
					begin
						mode_r <= sbcmr_pkg::ST_RESET;
						cnt_r <= 32'h0;
					end
					else
						cnt_r <= cnt_r + 32'h1;
				end
				sbcmr_pkg::ST_NORMAL:
				begin
					cnt_r <= 32'h0;
					if (mode_write && mode_select_bits == sbcmr_pkg::MODE_SEL_STOP)
						mode_r <= sbcmr_pkg::ST_STOP;
					else if (mode_write && mode_select_bits == sbcmr_pkg::MODE_SEL_SLEEP)
						mode_r <= sbcmr_pkg::ST_SLEEP;
				end
				sbcmr_pkg::ST_STOP:
				begin
					if (wake_any || cs_rise)
						mode_r <= wd_disabled ? sbcmr_pkg::ST_NORMAL : sbcmr_pkg::ST_NREQ;
				end
				sbcmr_pkg::ST_SLEEP:
				begin
					if (wake_any)
					begin
						mode_r <= sbcmr_pkg::ST_RESET;
						cnt_r <= 32'h0;
					end
				end
				default:
					mode_r <= sbcmr_pkg::ST_RESET;
			endcase
		end
	end

	// Wake arming captured on entry to a low-power mode
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wake_arm_r <= '0;
		else if (mode_r == sbcmr_pkg::ST_NORMAL && mode_write
			&& mode_select_bits != sbcmr_pkg::MODE_SEL_NORMAL)
			wake_arm_r <= wake_input_enable & ~wake_mux_select;
		else if (mode_r != sbcmr_pkg::ST_STOP && mode_r != sbcmr_pkg::ST_SLEEP)
			wake_arm_r <= '0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			wake_prev_r <= '0;
			wake_status_reg <= '0;
		end
		else
		begin
			wake_prev_r <= wake_input;
			wake_status_reg <= wake_input;
		end
	end

	// Wake source capture; CS and external reset wakes leave no bit
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wake_source_reg <= '0;
		else if ((mode_r == sbcmr_pkg::ST_STOP || mode_r == sbcmr_pkg::ST_SLEEP) && |wake_hit)
			wake_source_reg <= wake_source_reg | wake_hit;
		else if (source_read)
			wake_source_reg <= '0;
	end

	// Event detection per source, filtered by mode
	always_comb
	begin
		events = '0;
		if (mode_r == sbcmr_pkg::ST_STOP)
			events[sbcmr_pkg::SRC_WAKE] = wake_any;
		if (mode_r == sbcmr_pkg::ST_NORMAL || mode_r == sbcmr_pkg::ST_NREQ)
		begin
			events[sbcmr_pkg::SRC_LOW_V] = supply_undervoltage;
			events[sbcmr_pkg::SRC_HIGH_V] = supply_overvoltage;
			events[sbcmr_pkg::SRC_PREWARN] = temp_prewarn;
			events[sbcmr_pkg::SRC_LIN] = lin_overtemp || txd_stuck || rxd_short
				|| lin_overcurrent;
			events[sbcmr_pkg::SRC_HS_OT] = hs_overtemp;
			events[sbcmr_pkg::SRC_LS_OT] = ls_overtemp;
		end
	end

	// Sticky sources; new event wins over the read clear
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			interrupt_source_reg <= '0;
		else
			interrupt_source_reg <= (source_read ? 7'h0 : interrupt_source_reg) | events;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			lin_overcurrent_flag <= 1'b0;
		else if (lin_overcurrent)
			lin_overcurrent_flag <= 1'b1;
		else if (source_read)
			lin_overcurrent_flag <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			regulator_overtemp_flag <= 1'b0;
		else if (vdd_overtemp)
			regulator_overtemp_flag <= 1'b1;
		else if (source_read)
			regulator_overtemp_flag <= 1'b0;
	end

	// LIN driver latch-off until fault gone and acknowledged
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			lin_fault_r <= 1'b0;
		else if (lin_overtemp || txd_stuck || rxd_short)
			lin_fault_r <= 1'b1;
		else if (source_read)
			lin_fault_r <= 1'b0;
	end

	// Interrupt pin; an unread wake source lets only the wake interrupt through
	assign irq_ok = (mode_r == sbcmr_pkg::ST_NORMAL || mode_r == sbcmr_pkg::ST_NREQ
		|| mode_r == sbcmr_pkg::ST_STOP) && rst_pin_in && !rst_pin_oe;
	assign irq_pending = (wake_source_reg != '0) ? interrupt_source_reg[sbcmr_pkg::SRC_WAKE]
		: |(interrupt_source_reg & (interrupt_mask_reg | 7'h01));
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq_b <= 1'b1;
		else if (source_read)
			irq_b <= 1'b1;
		else if (irq_ok && irq_pending)
			irq_b <= 1'b0;
		else if (!irq_ok)
			irq_b <= 1'b1;
	end

	// Reset pin and function enables
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rst_pin_out <= 1'b0;
			rst_pin_oe <= 1'b1;
			vdd_enable <= 1'b0;
			vdd_low_power <= 1'b0;
			lin_tx_enable <= 1'b0;
			lin_rx_enable <= 1'b0;
			hs_cyclic_allowed <= 1'b0;
			peripherals_enable <= 1'b0;
			mode_state <= 3'h0;
		end
		else
		begin
			rst_pin_out <= 1'b0;
			// An external reset preloads the counter, so its release drives no extra low
			rst_pin_oe <= (mode_r == sbcmr_pkg::ST_RESET && !ext_rst
				&& cnt_r < 32'(RESET_EXT_CYCLES)) || int_reset;
			vdd_enable <= mode_r != sbcmr_pkg::ST_SLEEP && !vdd_overtemp;
			vdd_low_power <= mode_r == sbcmr_pkg::ST_STOP;
			lin_tx_enable <= mode_r == sbcmr_pkg::ST_NORMAL && !lin_fault_r
				&& !(lin_overtemp || txd_stuck || rxd_short);
			lin_rx_enable <= mode_r != sbcmr_pkg::ST_RESET;
			hs_cyclic_allowed <= mode_r == sbcmr_pkg::ST_STOP
				|| mode_r == sbcmr_pkg::ST_SLEEP;
			peripherals_enable <= mode_r == sbcmr_pkg::ST_NORMAL
				|| mode_r == sbcmr_pkg::ST_NREQ;
			mode_state <= mode_r;
		end
	end
endmodule

// ===== dv/sbcmr_ctrl_sva.sv
// Checker of the mode, interrupt, reset and wake-up controller
`timescale 1ns/1ps
module sbcmr_ctrl_sva #(
	parameter int RESET_EXT_CYCLES = 20
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Host side and faults
	input wire logic source_read,
	input wire logic rst_pin_in,
	input wire logic vdd_below_reset,
	input wire logic vdd_overtemp,
	input wire logic lin_overtemp,
	input wire logic txd_stuck,
	input wire logic rxd_short,
	input wire logic lin_overcurrent,
	// Outputs
	input wire logic rst_pin_oe,
	input wire logic irq_b,
	input wire logic lin_overcurrent_flag,
	input wire logic regulator_overtemp_flag,
	input wire logic [2:0] mode_state,
	input wire logic vdd_enable,
	input wire logic lin_tx_enable,
	input wire logic lin_rx_enable
);
	int held;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Cycles for which the reset output has been driven
	always_ff @(posedge clk)
		held <= (rst_pin_oe && rst_b) ? held + 1 : 0;
	irq_in_reset_a: assert property (rst_pin_oe && $past(rst_pin_oe) |-> irq_b)
		else $error("interrupt low while reset driven");
	irq_sleep_a: assert property (mode_state == 3'h4 && $past(mode_state) == 3'h4 |-> irq_b)
		else $error("interrupt in sleep");
	irq_release_a: assert property (source_read && !irq_b |=> irq_b)
		else $error("interrupt not released by read");
	lin_oc_a: assert property (lin_overcurrent |=> lin_overcurrent_flag)
		else $error("over-current flag missing");
	lin_fault_a: assert property (lin_overtemp || txd_stuck || rxd_short |=> !lin_tx_enable)
		else $error("driver on during fault");
	vdd_ot_a: assert property (vdd_overtemp |=> regulator_overtemp_flag && !vdd_enable)
		else $error("regulator not shut down");
	vdd_low_a: assert property (vdd_below_reset |-> ##[1:3] rst_pin_oe)
		else $error("no reset on low regulator");
	rst_extend_a: assert property ($fell(rst_pin_oe) |-> held >= RESET_EXT_CYCLES)
		else $error("reset released early");
	nreq_rx_a: assert property (mode_state == 3'h1 && $past(mode_state) == 3'h1 |-> lin_rx_enable && !lin_tx_enable)
		else $error("wrong transceiver state in normal request");
	ext_rst_a: assert property ((!rst_pin_in && !rst_pin_oe) [*6] |-> ##[0:2] mode_state == 3'h0)
		else $error("external reset ignored");
	cover property ($fell(irq_b));
	cover property ($fell(rst_pin_oe));
	cover property (mode_state == 3'h3 ##1 mode_state == 3'h1);
endmodule
bind sbcmr_ctrl sbcmr_ctrl_sva #(.RESET_EXT_CYCLES(RESET_EXT_CYCLES)) u_sva (.clk, .rst_b,
	.source_read, .rst_pin_in, .vdd_below_reset, .vdd_overtemp, .lin_overtemp, .txd_stuck,
	.rxd_short, .lin_overcurrent, .rst_pin_oe, .irq_b, .lin_overcurrent_flag,
	.regulator_overtemp_flag, .mode_state, .vdd_enable, .lin_tx_enable, .lin_rx_enable);

// ===== dv/sbcmr_host.sv
// Host model: reads the sources after an interrupt and may pull the reset line low
`timescale 1ns/1ps
module sbcmr_host (
	// Controls from the bench
	input wire logic clk,
	input wire logic ack_en,
	input wire logic [3:0] ack_wait,
	input wire logic ext_low,
	// Lines of the controller
	input wire logic irq_b,
	input wire logic rst_pin_oe,
	output logic source_read,
	output logic rst_pin_in
);
	int n = 0;
	// Reset line has a pull-up and is low while either side pulls
	assign rst_pin_in = !(rst_pin_oe || ext_low);
	initial
		source_read = 1'h0;
	always @(posedge clk)
	begin
		source_read <= 1'h0;
		if (!ack_en || irq_b || source_read)
			n <= 0;
		else if (n == ack_wait)
			source_read <= 1'h1;
		else
			n <= n + 1;
	end
endmodule

// ===== dv/sbcmr_ctrl_tb.sv
// Testbench of the mode, interrupt, reset and wake-up controller
`timescale 1ns/1ps
module sbcmr_ctrl_tb;
	logic clk, rst_b, mode_write, source_read, ack_en, ext_low, lin_overcurrent, lin_wake;
	logic vdd_overtemp, rst_pin_in, rst_pin_oe, irq_b, lin_overcurrent_flag;
	logic regulator_overtemp_flag, vdd_enable, lin_tx_enable, lin_rx_enable, peripherals_enable;
	logic vdd_low_power, hs_cyclic_allowed, cs_rise;
	logic [3:0] wake_mux_select;
	logic [1:0] mode_select_bits, rs;
	logic [2:0] lf, mode_state;
	logic [3:0] ack_wait, wake_input_enable, wake_input, wake_status_reg, wake_source_reg;
	logic [4:0] flt;
	logic [6:0] interrupt_mask_reg, interrupt_source_reg;
	int failures, check_count;
	sbcmr_ctrl #(.RESET_EXT_CYCLES(20), .NREQ_CYCLES(50)) dut (.clk, .rst_b, .mode_write,
		.mode_select_bits, .source_read, .interrupt_mask_reg, .wake_input_enable,
		.wake_mux_select, .wd_disabled(1'h0), .wd_fail(rs[1]),
		.supply_undervoltage(flt[0]), .supply_overvoltage(flt[1]), .temp_prewarn(flt[4]),
		.vdd_below_reset(rs[0]), .vdd_overtemp, .lin_overtemp(lf[0]), .txd_stuck(lf[1]),
		.rxd_short(lf[2]), .lin_overcurrent, .hs_overtemp(flt[2]), .ls_overtemp(flt[3]),
		.wake_input, .lin_wake, .timer_wake(1'h0), .cs_rise, .rst_pin_in,
		.rst_pin_out(), .rst_pin_oe, .irq_b, .interrupt_source_reg, .wake_status_reg,
		.wake_source_reg, .lin_overcurrent_flag, .regulator_overtemp_flag, .mode_state,
		.vdd_enable, .vdd_low_power, .lin_tx_enable, .lin_rx_enable,
		.hs_cyclic_allowed, .peripherals_enable);
	sbcmr_host host (.clk, .ack_en, .ack_wait, .ext_low, .irq_b, .rst_pin_oe, .source_read,
		.rst_pin_in);
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Waits, bounded, until the device stops driving reset
	task automatic up(output int c);
		c = 0;
		while (rst_pin_oe === 1'h1 && c < 200)
		begin
			cyc(1);
			c++;
		end
		cyc(2);
	endtask
	task automatic cmd(input logic [1:0] m);
		mode_select_bits = m;
		mode_write = 1'h1;
		cyc(1);
		mode_write = 1'h0;
		cyc(3);
	endtask
	task automatic ack();
		ack_en = 1'h1;
		cyc(18);
		ack_en = 1'h0;
	endtask
	task automatic t_power();
		int c;
		up(c);
		chk("ext_len", c >= 20, 1);
		chk("mode", mode_state, 3'h1);
		chk("lin", {lin_rx_enable, lin_tx_enable}, 2'h2);
		cyc(60);
		chk("timeout", rst_pin_oe, 1'h1);
		up(c);
		cmd(sbcmr_pkg::MODE_SEL_NORMAL);
		chk("mode", mode_state, 3'h2);
		$display("power done");
	endtask
	task automatic t_irq();
		int pos[5] = '{sbcmr_pkg::SRC_LOW_V, sbcmr_pkg::SRC_HIGH_V, sbcmr_pkg::SRC_HS_OT,
			sbcmr_pkg::SRC_LS_OT, sbcmr_pkg::SRC_PREWARN};
		for (int i = 0; i < 5; i++)
		begin
			flt[i] = 1'h1;
			cyc(4);
			chk("irq", irq_b, 1'h0);
			chk("src", interrupt_source_reg[pos[i]], 1'h1);
			flt[i] = 1'h0;
			ack_wait = 4'(i * 3);
			ack();
			chk("irq", irq_b, 1'h1);
			chk("src", interrupt_source_reg[pos[i]], 1'h0);
			interrupt_mask_reg = 7'h7f ^ (7'h1 << pos[i]);
			flt[i] = 1'h1;
			cyc(4);
			chk("masked", irq_b, 1'h1);
			flt[i] = 1'h0;
			interrupt_mask_reg = 7'h7f;
			ack();
		end
		$display("irq done");
	endtask
	task automatic t_lin();
		ack_wait = 4'h0;
		lin_overcurrent = 1'h1;
		cyc(3);
		chk("oc_flag", lin_overcurrent_flag, 1'h1);
		chk("oc_tx", lin_tx_enable, 1'h1);
		lin_overcurrent = 1'h0;
		ack();
		for (int i = 0; i < 3; i++)
		begin
			lf[i] = 1'h1;
			cyc(3);
			lf[i] = 1'h0;
			cyc(3);
			chk("tx_off", lin_tx_enable, 1'h0);
			ack();
			chk("tx_on", lin_tx_enable, 1'h1);
		end
		$display("lin done");
	endtask
	task automatic t_wake();
		int c;
		wake_input_enable = 4'h3;
		wake_mux_select = 4'h2;
		cmd(sbcmr_pkg::MODE_SEL_STOP);
		wake_input = 4'h2;
		cyc(4);
		chk("stop", mode_state, 3'h3);
		chk("stop_pw", {vdd_low_power, hs_cyclic_allowed, peripherals_enable}, 3'h6);
		wake_input = 4'h3;
		cyc(4);
		chk("wk_irq", irq_b, 1'h0);
		chk("wk_src", wake_source_reg[0], 1'h1);
		chk("wk_sts", wake_status_reg, 4'h3);
		chk("wk_mode", mode_state, 3'h1);
		ack();
		chk("wk_clr", wake_source_reg[0], 1'h0);
		cmd(sbcmr_pkg::MODE_SEL_NORMAL);
		cmd(sbcmr_pkg::MODE_SEL_STOP);
		cs_rise = 1'h1;
		cyc(1);
		cs_rise = 1'h0;
		cyc(3);
		chk("cs_wake", mode_state, 3'h1);
		chk("cs_src", {irq_b, interrupt_source_reg[0], wake_source_reg}, 6'h20);
		cmd(sbcmr_pkg::MODE_SEL_NORMAL);
		cmd(sbcmr_pkg::MODE_SEL_SLEEP);
		chk("vdd", {vdd_enable, peripherals_enable, irq_b}, 3'h1);
		lin_wake = 1'h1;
		cyc(1);
		lin_wake = 1'h0;
		cyc(3);
		chk("sl_rst", rst_pin_oe, 1'h1);
		up(c);
		cmd(sbcmr_pkg::MODE_SEL_NORMAL);
		$display("wake done");
	endtask
	task automatic t_rst();
		int c;
		ext_low = 1'h1;
		cyc(8);
		chk("ext", mode_state, 3'h0);
		ext_low = 1'h0;
		cyc(3);
		chk("ext_rel", mode_state, 3'h1);
		chk("ext_oe", rst_pin_oe, 1'h0);
		cmd(sbcmr_pkg::MODE_SEL_NORMAL);
		for (int i = 0; i < 2; i++)
		begin
			rs[i] = 1'h1;
			cyc(1);
			rs[1] = 1'h0;
			cyc(4);
			chk("rst", rst_pin_oe, 1'h1);
			rs = 2'h0;
			up(c);
			chk("rst_len", c >= 16, 1);
			cmd(sbcmr_pkg::MODE_SEL_NORMAL);
		end
		vdd_overtemp = 1'h1;
		cyc(3);
		chk("vdd_ot", {regulator_overtemp_flag, vdd_enable}, 2'h2);
		$display("reset done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#200000;
		failures++;
		give_verdict();
	end
	initial
	begin
		{rst_b, mode_write, ack_en, ext_low, lin_overcurrent, lin_wake, vdd_overtemp} = 7'h0;
		cs_rise = 1'h0;
		{mode_select_bits, rs, lf, flt, ack_wait, wake_input_enable, wake_input} = 24'h0;
		wake_mux_select = 4'h0;
		interrupt_mask_reg = 7'h7f;
		cyc(2);
		rst_b = 1'h1;
		t_power();
		t_irq();
		t_lin();
		t_wake();
		t_rst();
		give_verdict();
	end
endmodule
